/* File: rtl/flex_serial_pkg.sv */
// shared constants and carrier types of the flex serial status and flag bank
package flex_serial_pkg;

    // register byte offsets
    localparam logic [11:0] OFS_PIN_LEVEL = 12'h004;
    localparam logic [11:0] OFS_SHIFT_FLAG = 12'h008;
    localparam logic [11:0] OFS_SHIFT_ERR = 12'h00C;
    localparam logic [11:0] OFS_TIMER_FLAG = 12'h010;
    localparam logic [11:0] OFS_FLAG_IRQ_EN = 12'h018;
    localparam logic [11:0] OFS_EVENT_STATUS = 12'h040;
    localparam logic [11:0] OFS_EVENT_MASK = 12'h044;

    // field positions and widths
    localparam int NUM_SHIFT = 4;
    localparam int NUM_TIMER = 4;
    localparam int NUM_PIN = 8;
    localparam int EVT_FLAG_LSB = 0;
    localparam int EVT_ERR_LSB = 4;
    localparam int EVT_TIMER_LSB = 8;
    localparam int EVT_W = 12;

    // reset values
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [EVT_W-1:0] RST_EVT = 12'h000;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // pin synchroniser depth
    localparam int PIN_SYNC_STAGES = 3;

    // AHB transfer type and size codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // shifter operating selections
    typedef enum logic [2:0] {
        SHIFT_OFF = 3'b000,
        SHIFT_RX = 3'b001,
        SHIFT_TX = 3'b010,
        SHIFT_MATCH_STORE = 3'b100,
        SHIFT_MATCH_CONT = 3'b101
    } shifter_op_select_t;

    // timer operating selections
    typedef enum logic [1:0] {
        TIMER_OFF = 2'b00,
        TIMER_BAUD8 = 2'b01,
        TIMER_PWM8 = 2'b10,
        TIMER_CNT16 = 2'b11
    } timer_op_t;

    // events and levels from one shifter's datapath and its buffer port
    typedef struct packed {
        logic [2:0] op_select;
        logic buf_loaded;
        logic buf_moved;
        logic match_event;
        logic match_now;
        logic overrun;
        logic frame_err;
        logic underrun;
        logic buf_read;
        logic buf_write;
    } shifter_evt_t;

    // state of one timer's counter
    typedef struct packed {
        logic [1:0] mode;
        logic dec_active;
        logic [15:0] count;
    } timer_state_t;

endpackage

/* File: rtl/flex_serial_status_flags.sv */
// status, error and timer flag bank of the flex serial module with AHB-Lite slave
// Behaviour
// - read-only pin level register returns eight pin levels, upper bits zero
// - receive: flag set when buffer loaded from shifter, cleared on buffer read
// - transmit: flag set on mode entry or buffer move, cleared on buffer write
// - match store: flag set on match, cleared on buffer read
// - continuous match: flag follows the live match result, never latched
// - writing one clears a status flag except in continuous match; zero ignored
// - receive error: buffer overrun or start or stop bit mismatch
// - transmit error: buffer underrun when shifter needs unwritten data
// - match store error: new match before previous stored data was read
// - continuous match error: set on every match
// - error cleared by writing one; continuous match buffer read clears too
// - dual 8-bit baud timer flag set when upper half reaches zero decrementing
// - 8-bit PWM timer flag set when upper half reaches zero decrementing
// - 16-bit timer flag set on full count zero; held until write one
// - per-shifter enable gates its status flag onto the interrupt
// - status, error, timer flag and enable registers reset to zero
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/10ps

module flex_serial_status_flags (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic [7:0] pin_levels_in,
    input wire flex_serial_pkg::shifter_evt_t [3:0] shifter_evt_in,
    input wire flex_serial_pkg::timer_state_t [3:0] timer_state_in,
    output logic [3:0] shifter_flags_out,
    output logic status_irq_out,
    output logic event_irq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // true when a shifter runs the given selection
    function automatic logic op_is(input logic [2:0] op, input logic [2:0] want);
        op_is = (op == want);
    endfunction

    // timer expiry condition by mode
    function automatic logic timer_hit(input flex_serial_pkg::timer_state_t t);
        case (t.mode)
            flex_serial_pkg::TIMER_BAUD8: begin
                timer_hit = t.dec_active && (t.count[15:8] == 8'h00);
            end
            flex_serial_pkg::TIMER_PWM8: begin
                timer_hit = t.dec_active && (t.count[15:8] == 8'h00);
            end
            flex_serial_pkg::TIMER_CNT16: begin
                timer_hit = t.dec_active && (t.count == 16'h0000);
            end
            default: begin
                timer_hit = 1'b0;
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0] pin_sync1_r;
    logic [7:0] pin_sync2_r;
    logic [7:0] pin_sync3_r;
    logic [7:0] pin_level_r;
    logic [7:0] pin_level_nxt;
    logic [3:0] shift_flag_r;
    logic [3:0] shift_flag_nxt;
    logic [3:0] shift_err_r;
    logic [3:0] shift_err_nxt;
    logic [3:0] timer_flag_r;
    logic [3:0] timer_flag_nxt;
    logic [3:0] irq_en_r;
    logic [3:0] irq_en_nxt;
    logic [flex_serial_pkg::EVT_W-1:0] evt_r;
    logic [flex_serial_pkg::EVT_W-1:0] evt_nxt;
    logic [flex_serial_pkg::EVT_W-1:0] evt_mask_r;
    logic [flex_serial_pkg::EVT_W-1:0] evt_mask_nxt;
    logic [3:0] tx_prev_r;
    logic [3:0] timer_hit_prev_r;
    logic wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic status_irq_r;
    logic event_irq_r;

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    // a transfer is taken in its address phase; this slave never inserts waits
    wire bus_take = hsel_in && hready_in && htrans_in[1];
    // narrow accesses are ignored: only word transfers reach the registers
    wire bus_word = (hsize_in == flex_serial_pkg::HSIZE_WORD);
    wire rd_take = bus_take && !hwrite_in && bus_word;
    wire wr_take = bus_take && hwrite_in && bus_word;
    wire [11:0] rd_addr = haddr_in[11:0];
    wire rd_pin = rd_take && (rd_addr == flex_serial_pkg::OFS_PIN_LEVEL);
    wire rd_flag = rd_take && (rd_addr == flex_serial_pkg::OFS_SHIFT_FLAG);
    wire rd_err = rd_take && (rd_addr == flex_serial_pkg::OFS_SHIFT_ERR);
    wire rd_tmr = rd_take && (rd_addr == flex_serial_pkg::OFS_TIMER_FLAG);
    wire rd_en = rd_take && (rd_addr == flex_serial_pkg::OFS_FLAG_IRQ_EN);
    wire rd_evt = rd_take && (rd_addr == flex_serial_pkg::OFS_EVENT_STATUS);
    wire rd_mask = rd_take && (rd_addr == flex_serial_pkg::OFS_EVENT_MASK);
    // write data arrives one cycle later, in the data phase
    wire wr_flag = wr_pend_r && (wr_addr_r == flex_serial_pkg::OFS_SHIFT_FLAG);
    wire wr_err = wr_pend_r && (wr_addr_r == flex_serial_pkg::OFS_SHIFT_ERR);
    wire wr_tmr = wr_pend_r && (wr_addr_r == flex_serial_pkg::OFS_TIMER_FLAG);
    wire wr_en = wr_pend_r && (wr_addr_r == flex_serial_pkg::OFS_FLAG_IRQ_EN);
    wire wr_mask = wr_pend_r && (wr_addr_r == flex_serial_pkg::OFS_EVENT_MASK);
    // write-one-clear masks
    wire [3:0] w1c_flag = wr_flag ? hwdata_in[3:0] : 4'h0;
    wire [3:0] w1c_err = wr_err ? hwdata_in[3:0] : 4'h0;
    wire [3:0] w1c_tmr = wr_tmr ? hwdata_in[3:0] : 4'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // pin snapshot

    // levels change only once the second and third stages agree
    assign pin_level_nxt = (pin_sync2_r & pin_sync3_r)
        | (pin_level_r & (pin_sync2_r | pin_sync3_r));

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            pin_sync1_r <= 8'h00;
            pin_sync2_r <= 8'h00;
            pin_sync3_r <= 8'h00;
            pin_level_r <= 8'h00;
        end else begin
            pin_sync1_r <= pin_levels_in;
            pin_sync2_r <= pin_sync1_r;
            pin_sync3_r <= pin_sync2_r;
            pin_level_r <= pin_level_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shifter flag and error next state; a set always wins over a clear

    logic [3:0] flag_set;
    logic [3:0] err_set;
    logic [3:0] tx_enter;

    always_comb begin
        flag_set = 4'h0;
        err_set = 4'h0;
        tx_enter = 4'h0;
        shift_flag_nxt = shift_flag_r;
        shift_err_nxt = shift_err_r;
        for (int i = 0; i < flex_serial_pkg::NUM_SHIFT; i++) begin
            tx_enter[i] = op_is(shifter_evt_in[i].op_select, flex_serial_pkg::SHIFT_TX)
                && !tx_prev_r[i];
            case (shifter_evt_in[i].op_select)
                flex_serial_pkg::SHIFT_RX: begin
                    flag_set[i] = shifter_evt_in[i].buf_loaded;
                    err_set[i] = shifter_evt_in[i].overrun || shifter_evt_in[i].frame_err;
                    if (flag_set[i]) begin
                        shift_flag_nxt[i] = 1'b1;
                    end else if (shifter_evt_in[i].buf_read || w1c_flag[i]) begin
                        shift_flag_nxt[i] = 1'b0;
                    end
                end
                flex_serial_pkg::SHIFT_TX: begin
                    flag_set[i] = shifter_evt_in[i].buf_moved || tx_enter[i];
                    err_set[i] = shifter_evt_in[i].underrun;
                    if (flag_set[i]) begin
                        shift_flag_nxt[i] = 1'b1;
                    end else if (shifter_evt_in[i].buf_write || w1c_flag[i]) begin
                        shift_flag_nxt[i] = 1'b0;
                    end
                end
                flex_serial_pkg::SHIFT_MATCH_STORE: begin
                    flag_set[i] = shifter_evt_in[i].match_event;
                    // a match while the last stored match is still unread
                    err_set[i] = shifter_evt_in[i].match_event && shift_flag_r[i];
                    if (flag_set[i]) begin
                        shift_flag_nxt[i] = 1'b1;
                    end else if (shifter_evt_in[i].buf_read || w1c_flag[i]) begin
                        shift_flag_nxt[i] = 1'b0;
                    end
                end
                flex_serial_pkg::SHIFT_MATCH_CONT: begin
                    // live result; write one has no effect here
                    shift_flag_nxt[i] = shifter_evt_in[i].match_now;
                    flag_set[i] = shifter_evt_in[i].match_now && !shift_flag_r[i];
                    err_set[i] = shifter_evt_in[i].match_event;
                end
                default: begin
                    if (w1c_flag[i]) begin
                        shift_flag_nxt[i] = 1'b0;
                    end
                end
            endcase
            // error clear: write one, or a buffer read in continuous match
            if (err_set[i]) begin
                shift_err_nxt[i] = 1'b1;
            end else if (w1c_err[i] || (shifter_evt_in[i].buf_read
                && op_is(shifter_evt_in[i].op_select, flex_serial_pkg::SHIFT_MATCH_CONT))) begin
                shift_err_nxt[i] = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // timer flags

    logic [3:0] tmr_hit;
    logic [3:0] tmr_rise;

    // flag held until write one; a hit in the clearing cycle keeps it set
    always_comb begin
        tmr_hit = 4'h0;
        for (int j = 0; j < flex_serial_pkg::NUM_TIMER; j++) begin
            tmr_hit[j] = timer_hit(timer_state_in[j]);
        end
    end
    assign tmr_rise = tmr_hit & ~timer_hit_prev_r;
    assign timer_flag_nxt = tmr_hit | (timer_flag_r & ~w1c_tmr);

    ////////////////////////////////////////////////////////////////////////////////
    // enables, event status and mask

    assign irq_en_nxt = wr_en ? hwdata_in[3:0] : irq_en_r;
    assign evt_mask_nxt = wr_mask ? hwdata_in[flex_serial_pkg::EVT_W-1:0] : evt_mask_r;
    // events accumulate; a read clears, but a new event in that cycle survives
    wire [flex_serial_pkg::EVT_W-1:0] evt_new = {tmr_rise, err_set, flag_set};
    assign evt_nxt = evt_new | (rd_evt ? flex_serial_pkg::RST_EVT : evt_r);

    ////////////////////////////////////////////////////////////////////////////////
    // read data, captured in the address phase so it leaves a flip-flop

    assign hrdata_nxt = rd_pin ? {24'h000000, pin_level_r}
        : rd_flag ? {28'h0000000, shift_flag_r}
        : rd_err ? {28'h0000000, shift_err_r}
        : rd_tmr ? {28'h0000000, timer_flag_r}
        : rd_en ? {28'h0000000, irq_en_r}
        : rd_evt ? {20'h00000, evt_r}
        : rd_mask ? {20'h00000, evt_mask_r}
        : flex_serial_pkg::RST_RDATA;

    ////////////////////////////////////////////////////////////////////////////////
    // register update

    // all flag and enable state comes out of reset at zero
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            shift_flag_r <= flex_serial_pkg::RST_FLAGS;
            shift_err_r <= flex_serial_pkg::RST_FLAGS;
            timer_flag_r <= flex_serial_pkg::RST_FLAGS;
            irq_en_r <= flex_serial_pkg::RST_FLAGS;
            evt_r <= flex_serial_pkg::RST_EVT;
            evt_mask_r <= flex_serial_pkg::RST_EVT;
            tx_prev_r <= 4'h0;
            timer_hit_prev_r <= 4'h0;
        end else begin
            shift_flag_r <= shift_flag_nxt;
            shift_err_r <= shift_err_nxt;
            timer_flag_r <= timer_flag_nxt;
            irq_en_r <= irq_en_nxt;
            evt_r <= evt_nxt;
            evt_mask_r <= evt_mask_nxt;
            timer_hit_prev_r <= tmr_hit;
            for (int k = 0; k < flex_serial_pkg::NUM_SHIFT; k++) begin
                tx_prev_r[k] <= op_is(shifter_evt_in[k].op_select, flex_serial_pkg::SHIFT_TX);
            end
        end
    end

    // bus pipeline
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            hrdata_r <= flex_serial_pkg::RST_RDATA;
        end else begin
            wr_pend_r <= wr_take;
            wr_addr_r <= wr_take ? haddr_in[11:0] : wr_addr_r;
            hrdata_r <= hrdata_nxt;
        end
    end

    // interrupt levels, registered from the next flag values so they change on the same edge as the flags
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            status_irq_r <= 1'b0;
            event_irq_r <= 1'b0;
        end else begin
            status_irq_r <= |(shift_flag_nxt & irq_en_nxt);
            event_irq_r <= |(evt_nxt & evt_mask_nxt);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign hrdata_out = hrdata_r;
    assign hreadyout_out = 1'b1; // zero wait states; no flop needed for a constant
    assign hresp_out = 1'b0; // always OKAY
    assign shifter_flags_out = shift_flag_r;
    assign status_irq_out = status_irq_r;
    assign event_irq_out = event_irq_r;

endmodule

/* File: sim/flex_serial_status_flags_chk.sv */
// assertion checker for the flex serial status and flag bank
`timescale 1ns/10ps
module flex_serial_status_flags_chk (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [7:0] pin_levels_in,
    input wire flex_serial_pkg::shifter_evt_t [3:0] shifter_evt_in,
    input wire flex_serial_pkg::timer_state_t [3:0] timer_state_in,
    input wire logic [3:0] shifter_flags_out,
    input wire logic status_irq_out,
    input wire logic event_irq_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////////////////////////////////////////////
    // mode selections of the shifters watched here
    wire logic [2:0] op0 = shifter_evt_in[0].op_select;
    wire logic [2:0] op1 = shifter_evt_in[1].op_select;
    wire logic [2:0] op2 = shifter_evt_in[2].op_select;
    wire logic [2:0] op3 = shifter_evt_in[3].op_select;
    sequence s_rx_load;
        op0 == flex_serial_pkg::SHIFT_RX && shifter_evt_in[0].buf_loaded;
    endsequence
    sequence s_rx_read;
        op0 == flex_serial_pkg::SHIFT_RX && shifter_evt_in[0].buf_read
            && !shifter_evt_in[0].buf_loaded;
    endsequence
    sequence s_tx_entry;
        op1 == flex_serial_pkg::SHIFT_TX && $past(op1) != flex_serial_pkg::SHIFT_TX;
    endsequence
    sequence s_quiet;
        (shifter_flags_out == 4'h0) [*2];
    endsequence
    sequence s_pin_read;
        hsel_in && hready_in && htrans_in[1] && !hwrite_in && haddr_in[11:0] == 12'h004;
    endsequence
    property p_rx_set;
        s_rx_load |=> shifter_flags_out[0];
    endproperty
    property p_rx_clear;
        s_rx_read |=> !shifter_flags_out[0];
    endproperty
    property p_tx_entry;
        s_tx_entry |-> ##[1:2] shifter_flags_out[1];
    endproperty
    property p_store_set;
        op2 == flex_serial_pkg::SHIFT_MATCH_STORE && shifter_evt_in[2].match_event
            |=> shifter_flags_out[2];
    endproperty
    property p_cont_follow;
        $past(op3) == flex_serial_pkg::SHIFT_MATCH_CONT && !$past(sys_rst_in)
            |-> shifter_flags_out[3] == $past(shifter_evt_in[3].match_now);
    endproperty
    property p_irq_quiet;
        s_quiet |-> !status_irq_out;
    endproperty
    property p_irq_cause;
        status_irq_out |-> shifter_flags_out != 4'h0 || $past(shifter_flags_out) != 4'h0;
    endproperty
    property p_reset_zero;
        $past(sys_rst_in) |-> shifter_flags_out == 4'h0 && !status_irq_out && hrdata_out == 32'h0;
    endproperty
    property p_pin_upper;
        s_pin_read |=> hrdata_out[31:8] == 24'h0;
    endproperty
    property p_okay;
        hreadyout_out && !hresp_out;
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("rx load left flag clear");
    a_rx_clear: assert property (p_rx_clear) else $error("rx buffer read left flag set");
    a_tx_entry: assert property (p_tx_entry) else $error("tx entry left flag clear");
    a_store_set: assert property (p_store_set) else $error("store match left flag clear");
    a_cont_follow: assert property (p_cont_follow) else $error("cont flag not live");
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq with no flag");
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
    a_reset_zero: assert property (p_reset_zero) else $error("not zero after reset");
    a_pin_upper: assert property (p_pin_upper) else $error("pin upper bits set");
    a_okay: assert property (p_okay) else $error("bus wait or error seen");
endmodule
bind flex_serial_status_flags flex_serial_status_flags_chk i_chk (
    .clk_sys_in, .sys_rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
    .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .pin_levels_in,
    .shifter_evt_in, .timer_state_in, .shifter_flags_out, .status_irq_out, .event_irq_out
);

/* File: sim/flex_serial_status_flags_tb.sv */
// self-checking bench of the flex serial status and flag bank
`timescale 1ns/10ps
module flex_serial_status_flags_tb;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0] htrans = 2'h0;
    logic [7:0] pins = 8'hA5;
    flex_serial_pkg::shifter_evt_t [3:0] evt = '0;
    flex_serial_pkg::timer_state_t [3:0] tmr = '0;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, sirq, eirq;
    wire logic [3:0] flags;
    int fail_count = 0;
    int checked = 0;
    // flags, errors, timer flags, irq enable
    logic [11:0] ofs [4] = '{flex_serial_pkg::OFS_SHIFT_FLAG, flex_serial_pkg::OFS_SHIFT_ERR,
        flex_serial_pkg::OFS_TIMER_FLAG, flex_serial_pkg::OFS_FLAG_IRQ_EN};
    logic [1:0] tm [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
    logic [15:0] tc [4] = '{16'h00FF, 16'h0000, 16'h0001, 16'h0000};
    localparam flex_serial_pkg::shifter_evt_t P_LOAD = '{buf_loaded: 1'b1, default: '0};
    localparam flex_serial_pkg::shifter_evt_t P_MOVE = '{buf_moved: 1'b1, default: '0};
    localparam flex_serial_pkg::shifter_evt_t P_MATCH = '{match_event: 1'b1, default: '0};
    localparam flex_serial_pkg::shifter_evt_t P_OVR = '{overrun: 1'b1, default: '0};
    localparam flex_serial_pkg::shifter_evt_t P_FRM = '{frame_err: 1'b1, default: '0};
    localparam flex_serial_pkg::shifter_evt_t P_UND = '{underrun: 1'b1, default: '0};
    localparam flex_serial_pkg::shifter_evt_t P_RD = '{buf_read: 1'b1, default: '0};
    localparam flex_serial_pkg::shifter_evt_t P_WR = '{buf_write: 1'b1, default: '0};
    ////////////////////////////////////////////////////////////////////////////////
    flex_serial_status_flags i_dut (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(flex_serial_pkg::HSIZE_WORD),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .pin_levels_in(pins), .shifter_evt_in(evt), .timer_state_in(tmr),
        .shifter_flags_out(flags), .status_irq_out(sirq), .event_irq_out(eirq)
    );
    // 4 ns period
    always #2 clk_sys_in = ~clk_sys_in;
    ////////////////////////////////////////////////////////////////////////////////
    // compare, verdict and bounded wait for the bus answer
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("counts: %0d compared, %0d mismatched", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            fail_count++;
            results();
        end
    endtask
    // one single word transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= flex_serial_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // mode is settled one edge before any pulse so the two never collide
    task automatic mode(input int s, input logic [2:0] op);
        evt[s].op_select <= op;
        @(posedge clk_sys_in);
    endtask
    task automatic pulse(input int s, input flex_serial_pkg::shifter_evt_t m);
        evt[s] <= evt[s] | m;
        @(posedge clk_sys_in);
        evt[s] <= evt[s] & ~m;
    endtask
    // sel picks the line, sampled live after the wait, not when the task is called
    task automatic irq_is(input logic sel, input logic exp);
        repeat (2) @(posedge clk_sys_in);
        chk({31'h0, (sel ? eirq : sirq)}, {31'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_sys_in);
        for (int i = 0; i < 4; i++) begin
            rdc(ofs[i], 32'h0);
        end
        rdc(flex_serial_pkg::OFS_PIN_LEVEL, 32'h0000_00A5);
        xfer(1'b1, flex_serial_pkg::OFS_PIN_LEVEL, 32'hFFFF_FFFF);
        pins <= 8'h3C;
        repeat (6) @(posedge clk_sys_in);
        rdc(flex_serial_pkg::OFS_PIN_LEVEL, 32'h0000_003C);
        rdc(12'h030, 32'h0);
        $display("test reset and pins done");
        mode(0, flex_serial_pkg::SHIFT_RX);
        pulse(0, P_LOAD);
        rdc(ofs[0], 32'h1);
        chk({28'h0, flags}, 32'h1);
        pulse(0, P_RD);
        rdc(ofs[0], 32'h0);
        pulse(0, P_LOAD);
        xfer(1'b1, ofs[0], 32'h0);
        rdc(ofs[0], 32'h1);
        xfer(1'b1, ofs[0], 32'h1);
        rdc(ofs[0], 32'h0);
        pulse(0, P_OVR);
        rdc(ofs[1], 32'h1);
        xfer(1'b1, ofs[1], 32'h1);
        pulse(0, P_FRM);
        rdc(ofs[1], 32'h1);
        xfer(1'b1, ofs[1], 32'h1);
        rdc(ofs[1], 32'h0);
        $display("test receive done");
        mode(1, flex_serial_pkg::SHIFT_TX);
        @(posedge clk_sys_in);
        rdc(ofs[0], 32'h2);
        pulse(1, P_WR);
        rdc(ofs[0], 32'h0);
        pulse(1, P_MOVE);
        rdc(ofs[0], 32'h2);
        xfer(1'b1, ofs[0], 32'h2);
        rdc(ofs[0], 32'h0);
        pulse(1, P_UND);
        rdc(ofs[1], 32'h2);
        xfer(1'b1, ofs[1], 32'h2);
        $display("test transmit done");
        mode(2, flex_serial_pkg::SHIFT_MATCH_STORE);
        pulse(2, P_MATCH);
        rdc(ofs[0], 32'h4);
        pulse(2, P_MATCH);
        rdc(ofs[1], 32'h4);
        xfer(1'b1, ofs[1], 32'h4);
        pulse(2, P_RD);
        rdc(ofs[0], 32'h0);
        mode(3, flex_serial_pkg::SHIFT_MATCH_CONT);
        evt[3].match_now <= 1'b1;
        @(posedge clk_sys_in);
        rdc(ofs[0], 32'h8);
        xfer(1'b1, ofs[0], 32'h8);
        rdc(ofs[0], 32'h8);
        evt[3].match_now <= 1'b0;
        @(posedge clk_sys_in);
        rdc(ofs[0], 32'h0);
        pulse(3, P_MATCH);
        rdc(ofs[1], 32'h8);
        pulse(3, P_RD);
        rdc(ofs[1], 32'h0);
        $display("test match modes done");
        for (int i = 0; i < 4; i++) begin
            tmr[i] <= '{mode: tm[i], dec_active: 1'b1, count: tc[i]};
        end
        @(posedge clk_sys_in);
        for (int i = 0; i < 4; i++) begin
            tmr[i].dec_active <= 1'b0;
        end
        rdc(ofs[2], 32'hB);
        xfer(1'b1, ofs[2], 32'hF);
        rdc(ofs[2], 32'h0);
        $display("test timers done");
        xfer(1'b1, ofs[3], 32'hFFFF_FFFF);
        rdc(ofs[3], 32'hF);
        irq_is(1'b0, 1'b0);
        pulse(0, P_LOAD);
        irq_is(1'b0, 1'b1);
        xfer(1'b1, ofs[3], 32'hE);
        irq_is(1'b0, 1'b0);
        xfer(1'b1, ofs[3], 32'h1);
        irq_is(1'b0, 1'b1);
        xfer(1'b1, ofs[0], 32'h1);
        irq_is(1'b0, 1'b0);
        xfer(1'b0, flex_serial_pkg::OFS_EVENT_STATUS, 32'h0);
        xfer(1'b1, flex_serial_pkg::OFS_EVENT_MASK, 32'h0);
        pulse(0, P_OVR);
        irq_is(1'b1, 1'b0);
        xfer(1'b1, flex_serial_pkg::OFS_EVENT_MASK, 32'hFFF);
        irq_is(1'b1, 1'b1);
        xfer(1'b0, flex_serial_pkg::OFS_EVENT_STATUS, 32'h0);
        chk({31'h0, rd[4]}, 32'h1);
        irq_is(1'b1, 1'b0);
        $display("test interrupts done");
        results();
    end
endmodule
